//--- core/srcr_regs.sv
/*
 * Sparse radar configuration register bank. Holds the writable
 * configuration, captures service metadata and error flags, and derives
 * pacing and range controls for the radar service.
 * Assumes the serial register front end hands over one decoded access at a
 * time as single-cycle strobes with a byte offset, all on clk_i.
 */
//
// How it works
// [R1] Writable registers hold configuration; metadata refreshes on create or new data.
// [R2] Policy code 0x01 at 0x22 makes the sensor pace measurements exactly.
// [R3] Policy code 0x02 caps rate in software; rate zero removes the cap.
// [R4] Refresh rate at 0x23 counts in millihertz.
// [R5] Amplification at 0x24 accepts 0 to 1000, low to high.
// [R6] Power state codes: 0 off, 1 sleep, 2 ready, 3 active, 4 hibernate.
// [R7] Hibernate stops the oscillator; host toggles a pin to enter and leave.
// [R8] Profile accepts 0x01 to 0x05, resolution to loop gain.
// [R9] Ambiguity code 0x06 gives 11.5 m unambiguous, 7.0 m measurable.
// [R10] Ambiguity code 0x09 gives 17.3 m unambiguous, 12.7 m measurable.
// [R11] Offset 0x40 sets sweeps per frame.
// [R12] Offset 0x41 requests sweep rate in millihertz; zero means fastest.
// [R13] Offset 0x29 sets the decimation factor.
// [R14] Offset 0x30 sets hardware averaged samples per point.
// [R15] Offset 0x32 enables maximal attenuation against leakage saturation.
// [R16] Offset 0x33 switches asynchronous measurement on or off.
// [R17] Offsets 0x81 and 0x82 report sweep begin and span in millimetres.
// [R18] Offset 0x83 reports the sparse payload length.
// [R19] Offset 0x85 reports point spacing in micrometres.
// [R20] Offset 0xA0 flags saturated sensor data.
// [R21] Offset 0xA1 flags lost measurement data.
// [R22] Offset 0xA4 flags a failed sensor link.
// [R23] Writes to read-only registers are ignored.
`timescale 1ns/1ps
`default_nettype none

module srcr_regs
	import srcr_pkg::*;
(
	// Clock and reset.
	input wire logic clk_i,
	input wire logic rst_b_i,
	// Register access from the serial front end.
	input wire logic [ADDR_W-1:0] reg_addr_i,
	input wire logic reg_wr_i,
	input wire logic [DATA_W-1:0] reg_wdata_i,
	input wire logic reg_rd_i,
	output logic [DATA_W-1:0] reg_rdata_o,
	output logic reg_rvalid_o,
	output logic reg_wr_taken_o,
	// Service metadata and events.
	input wire logic svc_created_i,
	input wire logic data_produced_i,
	input wire srcr_meta_t meta_i,
	input wire logic saturated_i,
	input wire logic data_lost_i,
	input wire logic link_fault_i,
	// Configuration and controls toward the radar service.
	output srcr_cfg_t cfg_o,
	output srcr_ctrl_t ctrl_o
);

	srcr_cfg_t cfg_reg;
	srcr_meta_t meta_reg;
	srcr_ctrl_t ctrl_reg;
	logic saturation_flag_reg;
	logic lost_frame_flag_reg;
	logic radar_link_fault_flag_reg;
	logic [DATA_W-1:0] rdata_reg;
	logic rvalid_reg;
	logic wr_taken_reg;
	logic wr_ok;
	logic meta_load;

	// Offsets that hold writable configuration.
	function automatic logic is_config(input logic [7:0] a);
		case (a)
			OFS_RANGE_BEGIN, OFS_RANGE_SPAN, OFS_REPEAT_POLICY,
			OFS_REFRESH_RATE, OFS_RX_AMPLIFICATION, OFS_POWER_STATE,
			OFS_TX_MUTE, OFS_PROFILE, OFS_DECIMATION, OFS_HW_AVERAGING,
			OFS_ATTEN_BOOST, OFS_ASYNC_ENABLE, OFS_AMBIGUITY,
			OFS_FRAME_SWEEPS, OFS_REQ_SCAN_FREQ, OFS_SAMPLING:
				is_config = 1'b1;
			default:
				is_config = 1'b0;
		endcase
	endfunction

	// Coded registers only take the codes they define.
	function automatic logic code_ok(input logic [7:0] a,
		input logic [31:0] d);
		case (a)
			OFS_REPEAT_POLICY:
				code_ok = (d == REPEAT_SENSOR_PACED)
					|| (d == REPEAT_SOFT_CAPPED); // [R2] [R3]
			OFS_RX_AMPLIFICATION:
				code_ok = (d <= AMPLIFICATION_MAX); // [R5]
			OFS_POWER_STATE:
				code_ok = (d <= PWR_HIBERNATE); // [R6]
			OFS_PROFILE:
				code_ok = (d >= PROFILE_MIN) && (d <= PROFILE_MAX); // [R8]
			OFS_AMBIGUITY:
				code_ok = (d == AMBIG_SHORT) || (d == AMBIG_LONG); // [R9] [R10]
			OFS_SAMPLING:
				code_ok = (d == SAMPLING_A) || (d == SAMPLING_B);
			default:
				code_ok = 1'b1;
		endcase
	endfunction

	// Read-only offsets are not configuration, so writes there drop.
	assign wr_ok = reg_wr_i && is_config(reg_addr_i)
		&& code_ok(reg_addr_i, reg_wdata_i); // [R23]
	assign meta_load = svc_created_i || data_produced_i;

	// Configuration storage.
	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			cfg_reg.range_begin_mm <= RST_RANGE_BEGIN;
			cfg_reg.range_span_mm <= RST_RANGE_SPAN;
			cfg_reg.repeat_policy <= RST_REPEAT;
			cfg_reg.refresh_rate_millihz <= RST_REFRESH;
			cfg_reg.receiver_amplification <= RST_AMPLIFICATION;
			cfg_reg.radar_power_state <= RST_POWER;
			cfg_reg.transmitter_mute <= RST_ZERO;
			cfg_reg.waveform_profile_pick <= RST_PROFILE;
			cfg_reg.sample_decimation <= RST_ONE;
			cfg_reg.hw_averaging_count <= RST_ONE;
			cfg_reg.leakage_attenuation_boost <= RST_ZERO;
			cfg_reg.async_measure_enable <= RST_ONE;
			cfg_reg.ambiguity_range_code <= RST_AMBIGUITY;
			cfg_reg.frame_sweep_count <= RST_FRAME_SWEEPS;
			cfg_reg.requested_scan_frequency <= RST_ZERO;
			cfg_reg.sampling_scheme_pick <= SAMPLING_A;
		end
		else if (wr_ok) // [R1]
		begin
			case (reg_addr_i)
				OFS_RANGE_BEGIN:
					cfg_reg.range_begin_mm <= reg_wdata_i;
				OFS_RANGE_SPAN:
					cfg_reg.range_span_mm <= reg_wdata_i;
				OFS_REPEAT_POLICY:
					cfg_reg.repeat_policy <= reg_wdata_i; // [R2] [R3]
				OFS_REFRESH_RATE:
					cfg_reg.refresh_rate_millihz <= reg_wdata_i; // [R4]
				OFS_RX_AMPLIFICATION:
					cfg_reg.receiver_amplification <= reg_wdata_i; // [R5]
				OFS_POWER_STATE:
					cfg_reg.radar_power_state <= reg_wdata_i; // [R6]
				OFS_TX_MUTE:
					cfg_reg.transmitter_mute <= reg_wdata_i;
				OFS_PROFILE:
					cfg_reg.waveform_profile_pick <= reg_wdata_i; // [R8]
				OFS_DECIMATION:
					cfg_reg.sample_decimation <= reg_wdata_i; // [R13]
				OFS_HW_AVERAGING:
					cfg_reg.hw_averaging_count <= reg_wdata_i; // [R14]
				OFS_ATTEN_BOOST:
					cfg_reg.leakage_attenuation_boost <= reg_wdata_i; // [R15]
				OFS_ASYNC_ENABLE:
					cfg_reg.async_measure_enable <= reg_wdata_i; // [R16]
				OFS_AMBIGUITY:
					cfg_reg.ambiguity_range_code <= reg_wdata_i;
				OFS_FRAME_SWEEPS:
					cfg_reg.frame_sweep_count <= reg_wdata_i; // [R11]
				OFS_REQ_SCAN_FREQ:
					cfg_reg.requested_scan_frequency <= reg_wdata_i; // [R12]
				OFS_SAMPLING:
					cfg_reg.sampling_scheme_pick <= reg_wdata_i;
				default:
					cfg_reg <= cfg_reg;
			endcase
		end
	end

	// Metadata is captured when the service is created or emits data.
	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
			meta_reg <= '0;
		else if (meta_load)
			meta_reg <= meta_i; // [R1] [R17] [R18] [R19]
	end

	// A new event wins over the clear by a fresh service creation.
	function automatic logic sticky_next(input logic event_seen,
		input logic held, input logic clear);
		sticky_next = event_seen || (held && !clear);
	endfunction

	// Flags are sticky until the service is created again.
	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
			saturation_flag_reg <= 1'b0;
		else
			saturation_flag_reg <= sticky_next(saturated_i,
				saturation_flag_reg, svc_created_i); // [R20]
	end

	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
			lost_frame_flag_reg <= 1'b0;
		else
			lost_frame_flag_reg <= sticky_next(data_lost_i,
				lost_frame_flag_reg, svc_created_i); // [R21]
	end

	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
			radar_link_fault_flag_reg <= 1'b0;
		else
			radar_link_fault_flag_reg <= sticky_next(link_fault_i,
				radar_link_fault_flag_reg, svc_created_i); // [R22]
	end

	// Pacing and range controls derived from the configuration.
	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
			ctrl_reg <= '0;
		else
		begin
			ctrl_reg.sensor_paced <=
				(cfg_reg.repeat_policy == REPEAT_SENSOR_PACED); // [R2]
			ctrl_reg.soft_cap_active <=
				(cfg_reg.repeat_policy == REPEAT_SOFT_CAPPED)
				&& (cfg_reg.refresh_rate_millihz != RST_ZERO); // [R3]
			ctrl_reg.max_scan_rate <=
				(cfg_reg.requested_scan_frequency == RST_ZERO); // [R12]
			ctrl_reg.hibernate <=
				(cfg_reg.radar_power_state == PWR_HIBERNATE); // [R6]
			case (cfg_reg.ambiguity_range_code)
				AMBIG_SHORT:
				begin
					ctrl_reg.unamb_range_mm <= AMBIG_SHORT_UNAMB_MM; // [R9]
					ctrl_reg.max_distance_mm <= AMBIG_SHORT_MAXDIST_MM; // [R9]
				end
				default:
				begin
					ctrl_reg.unamb_range_mm <= AMBIG_LONG_UNAMB_MM; // [R10]
					ctrl_reg.max_distance_mm <= AMBIG_LONG_MAXDIST_MM; // [R10]
				end
			endcase
		end
	end

	// Read answer one cycle after the strobe; unmapped offsets read zero.
	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			rdata_reg <= '0;
			rvalid_reg <= 1'b0;
		end
		else
		begin
			rvalid_reg <= reg_rd_i;
			if (reg_rd_i)
			begin
				case (reg_addr_i)
					OFS_RANGE_BEGIN:
						rdata_reg <= cfg_reg.range_begin_mm;
					OFS_RANGE_SPAN:
						rdata_reg <= cfg_reg.range_span_mm;
					OFS_REPEAT_POLICY:
						rdata_reg <= cfg_reg.repeat_policy;
					OFS_REFRESH_RATE:
						rdata_reg <= cfg_reg.refresh_rate_millihz;
					OFS_RX_AMPLIFICATION:
						rdata_reg <= cfg_reg.receiver_amplification;
					OFS_POWER_STATE:
						rdata_reg <= cfg_reg.radar_power_state;
					OFS_TX_MUTE:
						rdata_reg <= cfg_reg.transmitter_mute;
					OFS_PROFILE:
						rdata_reg <= cfg_reg.waveform_profile_pick;
					OFS_DECIMATION:
						rdata_reg <= cfg_reg.sample_decimation;
					OFS_HW_AVERAGING:
						rdata_reg <= cfg_reg.hw_averaging_count;
					OFS_ATTEN_BOOST:
						rdata_reg <= cfg_reg.leakage_attenuation_boost;
					OFS_ASYNC_ENABLE:
						rdata_reg <= cfg_reg.async_measure_enable;
					OFS_AMBIGUITY:
						rdata_reg <= cfg_reg.ambiguity_range_code;
					OFS_FRAME_SWEEPS:
						rdata_reg <= cfg_reg.frame_sweep_count;
					OFS_REQ_SCAN_FREQ:
						rdata_reg <= cfg_reg.requested_scan_frequency;
					OFS_SAMPLING:
						rdata_reg <= cfg_reg.sampling_scheme_pick;
					OFS_SWEEP_BEGIN:
						rdata_reg <= meta_reg.sweep_begin_mm; // [R17]
					OFS_SWEEP_SPAN:
						rdata_reg <= meta_reg.sweep_span_mm; // [R17]
					OFS_PAYLOAD_SIZE:
						rdata_reg <= meta_reg.payload_size; // [R18]
					OFS_ACHIEVED_FREQ:
						rdata_reg <= meta_reg.achieved_scan_frequency;
					OFS_POINT_SPACING:
						rdata_reg <= meta_reg.point_spacing_um; // [R19]
					OFS_SATURATION:
						rdata_reg <= {31'h0000_0000, saturation_flag_reg};
					OFS_LOST_FRAME:
						rdata_reg <= {31'h0000_0000, lost_frame_flag_reg};
					OFS_LINK_FAULT:
						rdata_reg <= {31'h0000_0000, radar_link_fault_flag_reg};
					default:
						rdata_reg <= '0;
				endcase
			end
		end
	end

	// Write acknowledge pulse for every accepted configuration write.
	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
			wr_taken_reg <= 1'b0;
		else
			wr_taken_reg <= wr_ok;
	end

	// Outputs come straight from their flip-flops.
	assign reg_rdata_o = rdata_reg;
	assign reg_rvalid_o = rvalid_reg;
	assign reg_wr_taken_o = wr_taken_reg;
	assign cfg_o = cfg_reg;
	assign ctrl_o = ctrl_reg;

endmodule

`default_nettype wire

//--- core/srcr_pkg.sv
/*
 * Shared constants and types for the sparse radar configuration register
 * bank: register offsets, accepted codes, reset values and the carriers.
 * Assumes a byte-wide register offset from the serial register front end.
 */
package srcr_pkg;

	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;

	// Writable configuration offsets.
	localparam logic [7:0] OFS_RANGE_BEGIN = 8'h20;
	localparam logic [7:0] OFS_RANGE_SPAN = 8'h21;
	localparam logic [7:0] OFS_REPEAT_POLICY = 8'h22;
	localparam logic [7:0] OFS_REFRESH_RATE = 8'h23;
	localparam logic [7:0] OFS_RX_AMPLIFICATION = 8'h24;
	localparam logic [7:0] OFS_POWER_STATE = 8'h25;
	localparam logic [7:0] OFS_TX_MUTE = 8'h26;
	localparam logic [7:0] OFS_PROFILE = 8'h28;
	localparam logic [7:0] OFS_DECIMATION = 8'h29;
	localparam logic [7:0] OFS_HW_AVERAGING = 8'h30;
	localparam logic [7:0] OFS_ATTEN_BOOST = 8'h32;
	localparam logic [7:0] OFS_ASYNC_ENABLE = 8'h33;
	localparam logic [7:0] OFS_AMBIGUITY = 8'h34;
	localparam logic [7:0] OFS_FRAME_SWEEPS = 8'h40;
	localparam logic [7:0] OFS_REQ_SCAN_FREQ = 8'h41;
	localparam logic [7:0] OFS_SAMPLING = 8'h42;

	// Read-only metadata and flag offsets.
	localparam logic [7:0] OFS_SWEEP_BEGIN = 8'h81;
	localparam logic [7:0] OFS_SWEEP_SPAN = 8'h82;
	localparam logic [7:0] OFS_PAYLOAD_SIZE = 8'h83;
	localparam logic [7:0] OFS_ACHIEVED_FREQ = 8'h84;
	localparam logic [7:0] OFS_POINT_SPACING = 8'h85;
	localparam logic [7:0] OFS_SATURATION = 8'ha0;
	localparam logic [7:0] OFS_LOST_FRAME = 8'ha1;
	localparam logic [7:0] OFS_LINK_FAULT = 8'ha4;

	// Repetition policy codes.
	localparam logic [31:0] REPEAT_SENSOR_PACED = 32'h0000_0001;
	localparam logic [31:0] REPEAT_SOFT_CAPPED = 32'h0000_0002;

	// Power state codes.
	localparam logic [31:0] PWR_OFF = 32'h0000_0000;
	localparam logic [31:0] PWR_SLEEP = 32'h0000_0001;
	localparam logic [31:0] PWR_READY = 32'h0000_0002;
	localparam logic [31:0] PWR_ACTIVE = 32'h0000_0003;
	localparam logic [31:0] PWR_HIBERNATE = 32'h0000_0004;

	// Waveform profile code range.
	localparam logic [31:0] PROFILE_MIN = 32'h0000_0001;
	localparam logic [31:0] PROFILE_MAX = 32'h0000_0005;

	// Receiver amplification ceiling.
	localparam logic [31:0] AMPLIFICATION_MAX = 32'h0000_03e8;

	// Ambiguity range codes and their distances in millimetres.
	localparam logic [31:0] AMBIG_SHORT = 32'h0000_0006;
	localparam logic [31:0] AMBIG_LONG = 32'h0000_0009;
	localparam logic [31:0] AMBIG_SHORT_UNAMB_MM = 32'h0000_2cec;
	localparam logic [31:0] AMBIG_SHORT_MAXDIST_MM = 32'h0000_1b58;
	localparam logic [31:0] AMBIG_LONG_UNAMB_MM = 32'h0000_4394;
	localparam logic [31:0] AMBIG_LONG_MAXDIST_MM = 32'h0000_319c;

	// Sampling scheme codes.
	localparam logic [31:0] SAMPLING_A = 32'h0000_0000;
	localparam logic [31:0] SAMPLING_B = 32'h0000_0001;

	// Reset values of the configuration.
	localparam logic [31:0] RST_RANGE_BEGIN = 32'h0000_00c8;
	localparam logic [31:0] RST_RANGE_SPAN = 32'h0000_01f4;
	localparam logic [31:0] RST_REPEAT = REPEAT_SENSOR_PACED;
	localparam logic [31:0] RST_REFRESH = 32'h0000_2710;
	localparam logic [31:0] RST_AMPLIFICATION = 32'h0000_01f4;
	localparam logic [31:0] RST_POWER = PWR_ACTIVE;
	localparam logic [31:0] RST_ZERO = 32'h0000_0000;
	localparam logic [31:0] RST_ONE = 32'h0000_0001;
	localparam logic [31:0] RST_PROFILE = PROFILE_MIN;
	localparam logic [31:0] RST_AMBIGUITY = AMBIG_LONG;
	localparam logic [31:0] RST_FRAME_SWEEPS = 32'h0000_0010;

	// Configuration carried to the radar service.
	typedef struct packed {
		logic [31:0] range_begin_mm;
		logic [31:0] range_span_mm;
		logic [31:0] repeat_policy;
		logic [31:0] refresh_rate_millihz;
		logic [31:0] receiver_amplification;
		logic [31:0] radar_power_state;
		logic [31:0] transmitter_mute;
		logic [31:0] waveform_profile_pick;
		logic [31:0] sample_decimation;
		logic [31:0] hw_averaging_count;
		logic [31:0] leakage_attenuation_boost;
		logic [31:0] async_measure_enable;
		logic [31:0] ambiguity_range_code;
		logic [31:0] frame_sweep_count;
		logic [31:0] requested_scan_frequency;
		logic [31:0] sampling_scheme_pick;
	} srcr_cfg_t;

	// Metadata offered by the radar service.
	typedef struct packed {
		logic [31:0] sweep_begin_mm;
		logic [31:0] sweep_span_mm;
		logic [31:0] payload_size;
		logic [31:0] achieved_scan_frequency;
		logic [31:0] point_spacing_um;
	} srcr_meta_t;

	// Pacing and range controls drawn from the configuration.
	typedef struct packed {
		logic sensor_paced;
		logic soft_cap_active;
		logic max_scan_rate;
		logic hibernate;
		logic [31:0] unamb_range_mm;
		logic [31:0] max_distance_mm;
	} srcr_ctrl_t;

endpackage

//--- sim/srcr_regs_monitor.sv
/*
 * Assertion checker for the sparse radar configuration register bank.
 * Assumes it is bound to srcr_regs and sees only that module's ports.
 */
`timescale 1ns/1ps
`default_nettype none

module srcr_regs_monitor
	import srcr_pkg::*;
(
	// Clock and reset.
	input wire logic clk_i,
	input wire logic rst_b_i,
	// Register access.
	input wire logic [ADDR_W-1:0] reg_addr_i,
	input wire logic reg_wr_i,
	input wire logic [DATA_W-1:0] reg_wdata_i,
	input wire logic reg_rd_i,
	input wire logic [DATA_W-1:0] reg_rdata_o,
	input wire logic reg_rvalid_o,
	input wire logic reg_wr_taken_o,
	// Configuration and controls.
	input wire srcr_cfg_t cfg_o,
	input wire srcr_ctrl_t ctrl_o
);
	logic live_reg;

	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);

	// Marks edges where the controls already follow the configuration.
	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
			live_reg <= 1'b0;
		else
			live_reg <= 1'b1;
	end

	a_read_answer: assert property (reg_rd_i |=> reg_rvalid_o)
		else $error("read got no answer");
	a_answer_cause: assert property (reg_rvalid_o |-> $past(reg_rd_i))
		else $error("answer without read");
	a_rdata_holds: assert property (!reg_rvalid_o |-> $stable(reg_rdata_o))
		else $error("read data moved");
	a_ro_ignored: assert property (reg_wr_taken_o |->
		$past(reg_wr_i) && $past(reg_addr_i) < 8'h80)
		else $error("write taken at read-only place");
	a_amp_write: assert property ((reg_wr_i && reg_addr_i == 8'h24 &&
		reg_wdata_i <= AMPLIFICATION_MAX) |=> reg_wr_taken_o &&
		cfg_o.receiver_amplification == $past(reg_wdata_i))
		else $error("amplification not stored");
	a_amp_ceiling: assert property (cfg_o.receiver_amplification <= 32'h3e8)
		else $error("amplification over ceiling");
	a_power_codes: assert property (cfg_o.radar_power_state <= 32'h4)
		else $error("bad power state");
	a_profile_codes: assert property (cfg_o.waveform_profile_pick inside
		{[32'h1:32'h5]})
		else $error("bad profile");
	a_pacing_follows: assert property (live_reg |-> ctrl_o.sensor_paced ==
		($past(cfg_o.repeat_policy) == 32'h1))
		else $error("sensor pacing wrong");
	a_soft_cap: assert property (live_reg |-> ctrl_o.soft_cap_active ==
		($past(cfg_o.repeat_policy) == 32'h2 &&
		$past(cfg_o.refresh_rate_millihz) != 32'h0))
		else $error("soft cap wrong");
	a_ambig_range: assert property (live_reg |->
		($past(cfg_o.ambiguity_range_code) == 32'h6 ?
		ctrl_o.unamb_range_mm == 32'h2cec && ctrl_o.max_distance_mm == 32'h1b58 :
		ctrl_o.unamb_range_mm == 32'h4394 && ctrl_o.max_distance_mm == 32'h319c))
		else $error("range distances wrong");
	a_fastest_rate: assert property (live_reg |-> ctrl_o.max_scan_rate ==
		($past(cfg_o.requested_scan_frequency) == 32'h0))
		else $error("fastest rate wrong");
	a_hibernate_flag: assert property (live_reg |-> ctrl_o.hibernate ==
		($past(cfg_o.radar_power_state) == 32'h4))
		else $error("hibernate wrong");

	c_write_taken: cover property (reg_wr_taken_o);
	c_soft_cap: cover property (ctrl_o.soft_cap_active);
	c_hibernate: cover property (ctrl_o.hibernate);
endmodule

bind srcr_regs srcr_regs_monitor srcr_regs_monitor_i (.clk_i(clk_i),
	.rst_b_i(rst_b_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
	.reg_wdata_i(reg_wdata_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
	.reg_rvalid_o(reg_rvalid_o), .reg_wr_taken_o(reg_wr_taken_o),
	.cfg_o(cfg_o), .ctrl_o(ctrl_o));

`default_nettype wire

//--- sim/srcr_svc_model.sv
/*
 * Behavioural model of the radar service feeding the register bank.
 * Assumes bench requests are levels held for one clock cycle.
 */
`timescale 1ns/1ps
`default_nettype none

module srcr_svc_model
	import srcr_pkg::*;
(
	// Clock and reset.
	input wire logic clk_i,
	input wire logic rst_b_i,
	// Requests from the bench.
	input wire logic create_req_i,
	input wire logic produce_req_i,
	input wire logic [2:0] event_req_i,
	input wire logic [31:0] base_i,
	// Service outputs.
	output logic svc_created_o,
	output logic data_produced_o,
	output srcr_meta_t meta_o,
	output logic [2:0] events_o
);
	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			svc_created_o <= 1'b0;
			data_produced_o <= 1'b0;
			events_o <= 3'h0;
			meta_o <= '0;
		end
		else
		begin
			svc_created_o <= create_req_i;
			data_produced_o <= produce_req_i;
			events_o <= event_req_i;
			if (create_req_i || produce_req_i)
				meta_o <= {base_i, base_i + 32'h1, base_i + 32'h2,
					base_i + 32'h3, base_i + 32'h4};
			else
				meta_o <= ~meta_o;
		end
	end
endmodule

`default_nettype wire

//--- sim/test_srcr_regs.sv
/*
 * Self-checking bench for the sparse radar configuration register bank.
 * Assumes the strobe access protocol and the service model beside it.
 */
`timescale 1ns/1ps
`default_nettype none

module test_srcr_regs;
	import srcr_pkg::*;
	logic clk_i, rst_b_i, reg_wr_i, reg_rd_i, reg_rvalid_o, reg_wr_taken_o;
	logic [7:0] reg_addr_i;
	logic [31:0] reg_wdata_i, reg_rdata_o, base;
	logic create_req, produce_req, svc_created, data_produced;
	logic [2:0] event_req, events;
	srcr_meta_t meta;
	srcr_cfg_t cfg_o;
	srcr_ctrl_t ctrl_o;
	int fails, tests_run;
	logic [7:0] offs [16] = '{8'h20, 8'h21, 8'h22, 8'h23, 8'h24, 8'h25,
		8'h26, 8'h28, 8'h29, 8'h30, 8'h32, 8'h33, 8'h34, 8'h40, 8'h41, 8'h42};
	logic [31:0] rst_vals [16] = '{RST_RANGE_BEGIN, RST_RANGE_SPAN, RST_REPEAT,
		RST_REFRESH, RST_AMPLIFICATION, RST_POWER, RST_ZERO, RST_PROFILE,
		RST_ONE, RST_ONE, RST_ZERO, RST_ONE, RST_AMBIGUITY, RST_FRAME_SWEEPS,
		RST_ZERO, RST_ZERO};
	logic [31:0] new_vals [16] = '{32'h12c, 32'h3e8, 32'h2, 32'h0, 32'h3e8,
		32'h4, 32'h1, 32'h5, 32'h4, 32'h8, 32'h1, 32'h0, 32'h6, 32'h20,
		32'h1388, 32'h1};
	logic [7:0] ro_offs [8] = '{8'h81, 8'h82, 8'h83, 8'h84, 8'h85, 8'ha0,
		8'ha1, 8'ha4};

	srcr_svc_model srcr_svc_model_i (.clk_i(clk_i), .rst_b_i(rst_b_i),
		.create_req_i(create_req), .produce_req_i(produce_req),
		.event_req_i(event_req), .base_i(base), .svc_created_o(svc_created),
		.data_produced_o(data_produced), .meta_o(meta), .events_o(events));
	srcr_regs srcr_regs_i (.clk_i(clk_i), .rst_b_i(rst_b_i),
		.reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i),
		.reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
		.reg_rvalid_o(reg_rvalid_o), .reg_wr_taken_o(reg_wr_taken_o),
		.svc_created_i(svc_created), .data_produced_i(data_produced),
		.meta_i(meta), .saturated_i(events[0]), .data_lost_i(events[1]),
		.link_fault_i(events[2]), .cfg_o(cfg_o), .ctrl_o(ctrl_o));

	task automatic give_verdict;
		$display("checks %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic chk(input logic ok, input string msg);
		tests_run++;
		if (!ok)
		begin
			fails++;
			$display("ERROR %0t %s", $time, msg);
		end
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		@(negedge clk_i);
		reg_addr_i = a;
		reg_rd_i = 1'b1;
		@(negedge clk_i);
		reg_rd_i = 1'b0;
		chk(reg_rvalid_o === 1'b1 && reg_rdata_o === e, "read data");
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic t);
		@(negedge clk_i);
		reg_addr_i = a;
		reg_wdata_i = d;
		reg_wr_i = 1'b1;
		@(negedge clk_i);
		reg_wr_i = 1'b0;
		chk(reg_wr_taken_o === t, "write acceptance");
	endtask

	task automatic svc(input logic c, input logic p, input logic [2:0] ev,
		input logic [31:0] b);
		@(negedge clk_i);
		create_req = c;
		produce_req = p;
		event_req = ev;
		base = b;
		@(negedge clk_i);
		create_req = 1'b0;
		produce_req = 1'b0;
		event_req = 3'h0;
		@(negedge clk_i);
	endtask

	initial
	begin
		clk_i = 1'b0;
		forever #20 clk_i = ~clk_i;
	end

	initial
	begin
		#400000;
		fails++;
		give_verdict();
	end

	initial
	begin
		fails = 0;
		tests_run = 0;
		{rst_b_i, reg_wr_i, reg_rd_i, create_req, produce_req} = 5'h0;
		{reg_addr_i, reg_wdata_i, base, event_req} = '0;
		repeat (2) @(negedge clk_i);
		rst_b_i = 1'b1;
		@(negedge clk_i);
		for (int i = 0; i < 16; i++)
			rd(offs[i], rst_vals[i]);
		for (int i = 0; i < 8; i++)
			rd(ro_offs[i], 32'h0);
		chk(ctrl_o.sensor_paced === 1'b1, "reset pacing");
		chk(ctrl_o.unamb_range_mm === 32'h4394, "reset range");
		$display("test reset values done");
		for (int i = 0; i < 16; i++)
		begin
			wr(offs[i], new_vals[i], 1'b1);
			chk(cfg_o[511 - 32*i -: 32] === new_vals[i], "config out");
			rd(offs[i], new_vals[i]);
		end
		@(negedge clk_i);
		chk(ctrl_o.hibernate === 1'b1, "hibernate");
		chk(ctrl_o.soft_cap_active === 1'b0, "zero rate cap");
		chk(ctrl_o.max_distance_mm === 32'h1b58, "short range");
		chk(ctrl_o.unamb_range_mm === 32'h2cec, "short range");
		$display("test write readback done");
		wr(8'h23, 32'h3e8, 1'b1);
		@(negedge clk_i);
		chk(ctrl_o.soft_cap_active === 1'b1, "soft cap");
		for (int c = 0; c < 6; c++)
			wr(8'h25, 32'(c), c < 5);
		rd(8'h25, 32'h4);
		for (int c = 0; c < 7; c++)
			wr(8'h28, 32'(c), c > 0 && c < 6);
		rd(8'h28, 32'h5);
		wr(8'h24, 32'h3e9, 1'b0);
		rd(8'h24, 32'h3e8);
		wr(8'h24, 32'h0, 1'b1);
		wr(8'h22, 32'h3, 1'b0);
		wr(8'h22, 32'h1, 1'b1);
		wr(8'h34, 32'h7, 1'b0);
		wr(8'h34, 32'h9, 1'b1);
		wr(8'h41, 32'h0, 1'b1);
		@(negedge clk_i);
		chk(ctrl_o.sensor_paced === 1'b1, "sensor pacing");
		chk(ctrl_o.max_scan_rate === 1'b1, "fastest rate");
		chk(ctrl_o.max_distance_mm === 32'h319c, "long range");
		wr(8'h27, 32'h5, 1'b0);
		rd(8'h27, 32'h0);
		$display("test codes done");
		svc(1'b0, 1'b1, 3'h0, 32'h100);
		for (int k = 0; k < 5; k++)
			rd(ro_offs[k], 32'h100 + 32'(k));
		wr(8'h81, 32'h5, 1'b0);
		rd(8'h81, 32'h100);
		for (int k = 0; k < 3; k++)
		begin
			svc(1'b0, 1'b0, 3'(1 << k), 32'h100);
			rd(ro_offs[5 + k], 32'h1);
			if (k < 2)
				rd(ro_offs[6 + k], 32'h0);
		end
		wr(8'ha1, 32'h0, 1'b0);
		rd(8'ha1, 32'h1);
		svc(1'b1, 1'b0, 3'h0, 32'h200);
		for (int k = 5; k < 8; k++)
			rd(ro_offs[k], 32'h0);
		rd(8'h81, 32'h200);
		$display("test metadata and flags done");
		@(negedge clk_i);
		rst_b_i = 1'b0;
		repeat (2) @(negedge clk_i);
		rst_b_i = 1'b1;
		rd(8'h24, RST_AMPLIFICATION);
		$display("test second reset done");
		give_verdict();
	end
endmodule

`default_nettype wire
